// >>> design/xba_card.sv
// card end: one slot's io page with product id, a small register, dma and irq requests.
// assumes the host attachment issues one cycle at a time and waits for ack.
`timescale 1ns/1ps
module xba_card
   import xba_pkg::*;
#(
   parameter logic [2:0] SLOT = 3'h1,
   parameter logic [7:0] MAKER_A = 8'h41, // arbitrary letters
   parameter logic [7:0] MAKER_B = 8'h42,
   parameter logic [7:0] MAKER_C = 8'h43,
   parameter logic [15:0] PRODUCT = 16'h0001 // arbitrary
) (
   input wire logic core_clk,
   input wire logic rst_n,
   xba_if.card bus,
   input wire logic [15:0] irq_in,
   input wire logic [7:0] dreq_in,
   input wire logic lock_in,
   output logic [31:0] scratch
);
   logic [31:0] scratch_q, scratch_d, rdata_q, rdata_d;
   logic ack_q, ack_d;
   logic [15:0] irq_q, irq_d;
   logic [7:0] dreq_q, dreq_d;
   logic [15:0] code;
   logic hit;
   logic [3:0] page;

   assign code = xba_maker(MAKER_A, MAKER_B, MAKER_C);
   assign page = bus.addr[15:12];
   assign hit = bus.cyc && !ack_q && bus.kind == XBA_CYC_IO && page == {1'b0, SLOT};

   always_comb begin
      scratch_d = scratch_q;
      rdata_d = rdata_q;
      ack_d = hit;
      if (hit && !bus.wr && bus.addr[11:0] == ID_OFFSET) begin
         // byte sC80 carries the code's upper byte, little-endian lanes
         rdata_d = {PRODUCT[7:0], PRODUCT[15:8], code[7:0], code[15:8]};
      end else if (hit && !bus.wr) begin
         rdata_d = scratch_q;
      end else if (hit && bus.wr && bus.addr[11:0] != ID_OFFSET) begin
         for (int i = 0; i < 4; i++) begin
            if (bus.be[i]) begin
               scratch_d[i*8 +: 8] = bus.wdata[i*8 +: 8];
            end
         end
      end
      irq_d = irq_in & IRQ_CARD_MASK;
      dreq_d = dreq_in & (DMA_LOW_MASK | DMA_HIGH_MASK);
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         scratch_q <= 32'h0000_0000;
         rdata_q <= 32'h0000_0000;
         ack_q <= 1'b0;
         irq_q <= 16'h0000;
         dreq_q <= 8'h00;
      end else begin
         scratch_q <= scratch_d;
         rdata_q <= rdata_d;
         ack_q <= ack_d;
         irq_q <= irq_d;
         dreq_q <= dreq_d;
      end
   end

   assign bus.rdata = rdata_q;
   assign bus.ack = ack_q;
   assign bus.irq = irq_q;
   assign bus.dreq = dreq_q;
   assign bus.lock_req = lock_in; // request only; host never grants it
   assign scratch = scratch_q;
endmodule : xba_card

// >>> design/xba_host.sv
// host end: decodes host accesses into bus io or memory cycles, arbitrates dma, merges irqs.
// assumes host_req is held until host_done; host data is big-endian.
`timescale 1ns/1ps
module xba_host
   import xba_pkg::*;
#(
   parameter int TIMEOUT = 255
) (
   input wire logic core_clk,
   input wire logic rst_n,
   xba_if.host bus,
   input wire logic host_req,
   input wire logic host_wr,
   input wire logic [31:0] host_addr,
   input wire xba_size_t host_size,
   input wire logic [31:0] host_wdata,
   output logic host_done,
   output logic host_err,
   output logic [31:0] host_rdata,
   output logic host_irq,
   output logic [7:0] dma_grant
);
   typedef enum logic [2:0] {XBA_IDLE = 3'b001, XBA_WAIT = 3'b010, XBA_DONE = 3'b100} xba_state_t;
   xba_state_t state_q, state_d;
   logic cyc_q, cyc_d, wr_q, wr_d, done_q, done_d, err_q, err_d, irq_q, irq_d;
   xba_cyc_t kind_q, kind_d;
   logic [31:0] addr_q, addr_d, wdata_q, wdata_d, rdata_q, rdata_d;
   logic [3:0] be_q, be_d;
   logic [7:0] cnt_q, cnt_d, gnt_q, gnt_d;
   logic [2:0] rot_lo_q, rot_lo_d, rot_hi_q, rot_hi_d;
   logic [1:0] turn_q, turn_d;
   xba_cyc_t dec;
   logic [31:0] lanes;

   function automatic logic [3:0] size_be(input xba_size_t s, input logic [1:0] a);
      case (s)
         XBA_SZ_8: return 4'h1 << a;
         XBA_SZ_16: return a[1] ? 4'hC : 4'h3;
         default: return 4'hF;
      endcase
   endfunction : size_be

   // pick first requester at or after the rotating pointer inside a group
   function automatic logic [7:0] rr_pick(input logic [7:0] req, input logic [2:0] ptr);
      logic [7:0] g;
      logic [2:0] idx;
      g = 8'h00;
      for (int i = 0; i < 8; i++) begin
         idx = 3'(ptr + 3'(i));
         if (g == 8'h00 && req[idx]) begin
            g[idx] = 1'b1;
         end
      end
      return g;
   endfunction : rr_pick

   function automatic logic [2:0] enc(input logic [7:0] g);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 0; i < 8; i++) begin
         if (g[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction : enc

   always_comb begin
      if (host_addr >= MEM_BASE && host_addr <= MEM_LIMIT) begin
         dec = XBA_CYC_MEM;
      end else if (host_addr <= IO_LIMIT) begin
         dec = XBA_CYC_IO;
      end else begin
         dec = XBA_CYC_NONE;
      end
   end

   // big-endian host word to little-endian bus word, for every width
   assign lanes = xba_swap(host_wdata);

   always_comb begin
      state_d = state_q;
      cyc_d = cyc_q;
      kind_d = kind_q;
      wr_d = wr_q;
      addr_d = addr_q;
      be_d = be_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      done_d = 1'b0;
      err_d = 1'b0;
      cnt_d = cnt_q;
      case (state_q)
         XBA_IDLE: begin
            if (host_req && dec == XBA_CYC_NONE) begin
               done_d = 1'b1;
               err_d = 1'b1;
               state_d = XBA_DONE;
            end else if (host_req) begin
               cyc_d = 1'b1;
               kind_d = dec;
               wr_d = host_wr;
               // io page and offset go out as a bus address; slot 1 id at 1C80 is one word
               addr_d = dec == XBA_CYC_IO ? {16'h0000, host_addr[19:16] , host_addr[PAGE_BITS-1:0]}
                                          : host_addr;
               be_d = size_be(host_size, host_addr[1:0]);
               wdata_d = lanes;
               cnt_d = 8'h00;
               state_d = XBA_WAIT;
            end
         end
         XBA_WAIT: begin
            cnt_d = 8'(cnt_q + 8'h01);
            if (bus.ack) begin
               cyc_d = 1'b0;
               rdata_d = xba_swap(bus.rdata);
               done_d = 1'b1;
               state_d = XBA_DONE;
            end else if (cnt_q == 8'(TIMEOUT)) begin
               cyc_d = 1'b0;
               done_d = 1'b1;
               err_d = 1'b1;
               state_d = XBA_DONE;
            end
         end
         XBA_DONE: begin
            if (!host_req) begin
               state_d = XBA_IDLE;
            end
         end
         default: state_d = XBA_IDLE;
      endcase
   end

   always_comb begin
      logic [7:0] lo, hi;
      lo = rr_pick(bus.dreq & DMA_LOW_MASK, rot_lo_q);
      hi = rr_pick(bus.dreq & DMA_HIGH_MASK, rot_hi_q);
      gnt_d = 8'h00;
      rot_lo_d = rot_lo_q;
      rot_hi_d = rot_hi_q;
      turn_d = turn_q;
      // high group gets HIGH_TURNS grants per low-group grant
      if (hi != 8'h00 && (turn_q != 2'h0 || lo == 8'h00)) begin
         gnt_d = hi;
         rot_hi_d = enc(hi) == 3'h7 ? 3'h5 : 3'(enc(hi) + 3'h1);
         turn_d = turn_q == 2'h0 ? 2'h0 : 2'(turn_q - 2'h1);
      end else if (lo != 8'h00) begin
         gnt_d = lo;
         rot_lo_d = 3'(enc(lo) + 3'h1) & 3'h3;
         turn_d = HIGH_TURNS;
      end
      irq_d = |(bus.irq & IRQ_CARD_MASK);
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_q <= XBA_IDLE;
         cyc_q <= 1'b0;
         kind_q <= XBA_CYC_NONE;
         wr_q <= 1'b0;
         addr_q <= 32'h0000_0000;
         be_q <= 4'h0;
         wdata_q <= 32'h0000_0000;
         rdata_q <= 32'h0000_0000;
         done_q <= 1'b0;
         err_q <= 1'b0;
         cnt_q <= 8'h00;
         gnt_q <= 8'h00;
         rot_lo_q <= 3'h0;
         rot_hi_q <= 3'h5;
         turn_q <= HIGH_TURNS;
         irq_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cyc_q <= cyc_d;
         kind_q <= kind_d;
         wr_q <= wr_d;
         addr_q <= addr_d;
         be_q <= be_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         done_q <= done_d;
         err_q <= err_d;
         cnt_q <= cnt_d;
         gnt_q <= gnt_d;
         rot_lo_q <= rot_lo_d;
         rot_hi_q <= rot_hi_d;
         turn_q <= turn_d;
         irq_q <= irq_d;
      end
   end

   assign bus.cyc = cyc_q;
   assign bus.kind = kind_q;
   assign bus.wr = wr_q;
   assign bus.addr = addr_q;
   assign bus.be = be_q;
   assign bus.wdata = wdata_q;
   assign bus.dack = gnt_q;
   assign bus.lock_gnt = 1'b0;
   assign host_done = done_q;
   assign host_err = err_q;
   assign host_rdata = rdata_q;
   assign host_irq = irq_q;
   assign dma_grant = gnt_q;
endmodule : xba_host

// >>> inc/xba_if.sv
// link between host attachment and card end: cycle strobe, data, dma and irq lines.
// assumes both ends share core_clk and rst_n.
`timescale 1ns/1ps
interface xba_if;
   import xba_pkg::*;
   logic cyc;
   xba_cyc_t kind;
   logic wr;
   logic [31:0] addr;
   logic [3:0] be;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic ack;
   logic [7:0] dreq;
   logic [7:0] dack;
   logic [15:0] irq;
   logic lock_req;
   logic lock_gnt;
   modport host (output cyc, kind, wr, addr, be, wdata, dack, lock_gnt,
                 input rdata, ack, dreq, irq, lock_req);
   modport card (input cyc, kind, wr, addr, be, wdata, dack, lock_gnt,
                 output rdata, ack, dreq, irq, lock_req);
endinterface : xba_if

// >>> inc/xba_pkg.sv
// package for the expansion bus host attachment: address map, slot paging, ids, irq map.
// assumes a single 25 MHz clock and a synchronous active-low reset shared by both ends.
// What this block does
// - rotate dma grants, favour channels five to seven
// - lines 0-2, 8, 13 reserved; cards never drive
// - cards use 3-7, 9-12, 14, 15 lines
// - all card interrupts merge into one output
// - carry byte, halfword and word transfers
// - decode two ranges into io or memory cycles
// - io space paged 4 KB per slot
// - never grant or hold a locked cycle
// - bus data little-endian, host big-endian
// - card shows four-byte id at sC80-sC83
// - slot one id read is one word at 1C80
// - first two id bytes hold maker code
// - letter minus 40 hex, keep five bits
// - code is zero then three letters, first highest
package xba_pkg;
   localparam logic [31:0] IO_BASE = 32'h0000_0000;
   localparam logic [31:0] IO_LIMIT = 32'h0004_FFFF;
   localparam logic [31:0] MEM_BASE = 32'h000A_0000;
   localparam logic [31:0] MEM_LIMIT = 32'h06FF_FFFF;
   localparam int PAGE_BITS = 12;
   localparam logic [11:0] ID_OFFSET = 12'hC80;
   localparam logic [15:0] SLOT1_ID_ADDR = 16'h1C80;
   localparam logic [7:0] ASCII_BIAS = 8'h40;
   localparam logic [15:0] IRQ_CARD_MASK = 16'hDEF8;
   localparam logic [7:0] DMA_LOW_MASK = 8'h0F;
   localparam logic [7:0] DMA_HIGH_MASK = 8'hE0;
   localparam logic [1:0] HIGH_TURNS = 2'h2;
   typedef enum logic [1:0] {XBA_SZ_8 = 2'h0, XBA_SZ_16 = 2'h1, XBA_SZ_32 = 2'h2} xba_size_t;
   typedef enum logic [1:0] {XBA_CYC_NONE = 2'h0, XBA_CYC_IO = 2'h1, XBA_CYC_MEM = 2'h2} xba_cyc_t;

   function automatic logic [4:0] xba_letter(input logic [7:0] ascii);
      logic [7:0] diff;
      diff = ascii - ASCII_BIAS;
      return diff[4:0];
   endfunction : xba_letter

   function automatic logic [15:0] xba_maker(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
      return {1'b0, xba_letter(a), xba_letter(b), xba_letter(c)};
   endfunction : xba_maker

   function automatic logic [31:0] xba_swap(input logic [31:0] w);
      return {w[7:0], w[15:8], w[23:16], w[31:24]};
   endfunction : xba_swap
endpackage : xba_pkg

// >>> test/tb.sv
// bench joining host attachment and one slot-1 card through the link interface.
// assumes the 25 MHz clock and a reset held 16 cycles at start.
`timescale 1ns/1ps
module tb;
   import xba_pkg::*;
   logic core_clk, rst_n, host_req, host_wr, host_done, host_err, host_irq, lock_in, er;
   logic [31:0] host_addr, host_wdata, host_rdata, scratch, rd, last_addr;
   logic [15:0] irq_in;
   logic [7:0] dreq_in, dma_grant;
   logic [3:0] last_be;
   xba_size_t host_size;
   xba_cyc_t last_kind;
   int errors, n_tests;
   xba_if bus();
   // short timeout keeps unanswered cycles quick
   xba_host #(.TIMEOUT(8)) xba_host_i (.core_clk(core_clk), .rst_n(rst_n), .bus(bus), .host_req(host_req),
      .host_wr(host_wr), .host_addr(host_addr), .host_size(host_size), .host_wdata(host_wdata),
      .host_done(host_done), .host_err(host_err), .host_rdata(host_rdata), .host_irq(host_irq),
      .dma_grant(dma_grant));
   // slot 1 and first letter A are the card's defaults
   xba_card #(.MAKER_B(8'h5A), .MAKER_C(8'h41), .PRODUCT(16'h1234)) xba_card_i (
      .core_clk(core_clk), .rst_n(rst_n), .bus(bus), .irq_in(irq_in), .dreq_in(dreq_in), .lock_in(lock_in),
      .scratch(scratch));
   xba_chk #(.TIMEOUT(8)) xba_chk_i (.core_clk(core_clk), .rst_n(rst_n), .cyc(bus.cyc), .kind(bus.kind),
      .addr(bus.addr),
      .be(bus.be), .ack(bus.ack), .dreq(bus.dreq), .dack(bus.dack), .irq(bus.irq), .lock_gnt(bus.lock_gnt));

   always @(posedge core_clk) begin
      if (bus.cyc === 1'b1) begin
         last_be <= bus.be;
         last_addr <= bus.addr;
         last_kind <= bus.kind;
      end
   end

   task automatic conclude();
      if (errors == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : conclude

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic access(input logic w, input logic [31:0] a, input xba_size_t s, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      host_req <= 1'b1;
      host_wr <= w;
      host_addr <= a;
      host_size <= s;
      host_wdata <= d;
      do begin
         @(posedge core_clk);
         n++;
      end while (host_done !== 1'b1 && n < 40);
      rd = host_rdata;
      er = host_err;
      host_req <= 1'b0;
      if (n >= 40) begin
         errors++;
         conclude();
      end
      @(posedge core_clk);
   endtask : access

   function automatic logic [4:0] pack5(input logic [7:0] c);
      logic [7:0] t;
      t = c - 8'h40;
      return t[4:0];
   endfunction : pack5

   task automatic t_id();
      logic [15:0] code;
      code = {1'b0, pack5(8'h41), pack5(8'h5A), pack5(8'h41)};
      check({16'h0, code}, 32'h0000_0741);
      access(1'b0, 32'h0001_1C80, XBA_SZ_32, 32'h0);
      check(rd, {code, 8'h12, 8'h34});
      check({last_addr[15:0], 12'h0, last_be}, 32'h1C80_000F);
      check(32'(last_kind), 32'(XBA_CYC_IO));
   endtask : t_id

   task automatic t_sizes();
      access(1'b1, 32'h0001_1000, XBA_SZ_8, 32'hAB00_0000);
      check({28'h0, last_be}, 32'h1);
      access(1'b1, 32'h0001_1000, XBA_SZ_16, 32'hABCD_0000);
      check({28'h0, last_be}, 32'h3);
      access(1'b1, 32'h0001_1002, XBA_SZ_16, 32'h0000_5566);
      check({28'h0, last_be}, 32'hC);
      access(1'b1, 32'h0001_1003, XBA_SZ_8, 32'h0000_0077);
      check({28'h0, last_be}, 32'h8);
      check(scratch, 32'h7755_CDAB);
      access(1'b1, 32'h0001_1000, XBA_SZ_32, 32'h1122_3344);
      check({28'h0, last_be}, 32'hF);
      check(scratch, 32'h4433_2211);
      access(1'b0, 32'h0001_1000, XBA_SZ_32, 32'h0);
      check(rd, 32'h1122_3344);
   endtask : t_sizes

   task automatic t_decode();
      access(1'b0, 32'h0005_0000, XBA_SZ_32, 32'h0);
      check(32'(er), 32'h1);
      access(1'b0, 32'h000A_0000, XBA_SZ_32, 32'h0);
      check({31'h0, er}, 32'h1);
      check(32'(last_kind), 32'(XBA_CYC_MEM));
      access(1'b0, 32'h0002_1C80, XBA_SZ_32, 32'h0);
      check({28'h0, last_addr[15:12]}, 32'h2);
   endtask : t_decode

   task automatic t_irq();
      for (int i = 0; i < 16; i++) begin
         @(posedge core_clk);
         irq_in <= 16'h1 << i;
         repeat (4) @(posedge core_clk);
         check(32'(host_irq), 32'(!(i inside {0, 1, 2, 8, 13})));
      end
      irq_in <= 16'h0;
   endtask : t_irq

   task automatic t_dma();
      int hi, lo;
      logic [7:0] seen;
      hi = 0;
      lo = 0;
      seen = 8'h0;
      @(posedge core_clk);
      dreq_in <= 8'hEF;
      lock_in <= 1'b1;
      repeat (40) begin
         @(posedge core_clk);
         seen = seen | dma_grant;
         hi += int'((dma_grant & 8'hE0) != 8'h0);
         lo += int'((dma_grant & 8'h0F) != 8'h0);
      end
      dreq_in <= 8'h0;
      lock_in <= 1'b0;
      check({24'h0, seen}, 32'hEF);
      check(32'(hi > lo && lo > 0), 32'h1);
   endtask : t_dma

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   initial begin
      errors = 0;
      n_tests = 0;
      rst_n = 1'b0;
      host_req = 1'b0;
      host_wr = 1'b0;
      host_addr = 32'h0;
      host_size = XBA_SZ_32;
      host_wdata = 32'h0;
      irq_in = 16'h0;
      dreq_in = 8'h0;
      lock_in = 1'b0;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      t_id();
      t_sizes();
      t_decode();
      t_irq();
      t_dma();
      conclude();
   end
endmodule : tb

// >>> test/xba_chk.sv
// checker on the link between host attachment and card end.
// assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
module xba_chk
   import xba_pkg::*;
#(
   parameter int TIMEOUT = 255
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic cyc,
   input wire xba_cyc_t kind,
   input wire logic [31:0] addr,
   input wire logic [3:0] be,
   input wire logic ack,
   input wire logic [7:0] dreq,
   input wire logic [7:0] dack,
   input wire logic [15:0] irq,
   input wire logic lock_gnt
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // cycles the current bus cycle has gone unanswered; the host may abandon it once its timeout runs out
   int wait_cnt;
   always_ff @(posedge core_clk) begin
      if (!rst_n || !cyc || ack) begin
         wait_cnt <= 0;
      end else begin
         wait_cnt <= wait_cnt + 1;
      end
   end
   a_lock_never: assert property (lock_gnt == 1'b0) else $error("lock granted");
   a_grant_onehot: assert property ($onehot0(dack) && dack[4] == 1'b0) else $error("bad grant");
   a_grant_asked: assert property (dack != 8'h00 |-> (dack & $past(dreq)) != 8'h00) else $error("grant unasked");
   a_cyc_kind: assert property (cyc |-> kind inside {XBA_CYC_IO, XBA_CYC_MEM}) else $error("bad kind");
   a_io_paged: assert property (cyc && kind == XBA_CYC_IO |-> addr[31:16] == 16'h0000) else $error("io addr");
   // address, kind and byte lanes must hold until the answer, or the card may latch a torn cycle
   a_cyc_hold: assert property (cyc && !ack && wait_cnt < TIMEOUT |=> cyc && $stable(addr) && $stable(kind) && $stable(be))
      else $error("cycle changed");
   a_cyc_abandon: assert property (cyc && !ack && wait_cnt == TIMEOUT |=> !cyc)
      else $error("cycle not abandoned");
   a_lane_shape: assert property (cyc |-> be inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF})
      else $error("bad lanes");
   a_slot_answer: assert property ($rose(cyc) && kind == XBA_CYC_IO && addr[15:12] == 4'h1 |-> ##1 ack ##1 !ack && !cyc)
      else $error("no answer");
   a_irq_reserved: assert property ((irq & 16'h2107) == 16'h0000) else $error("reserved irq");
endmodule : xba_chk
